//--- bench/ssr_gpib_host.sv
/*
 * bus controller model: serial poll on request after a lag, or on demand.
 * samples on the falling edge; assumes inputs change at the rising edge.
 */
`timescale 1ns/1ps
module ssr_gpib_host (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic auto_en,
    input wire logic force_poll,
    input wire logic [3:0] lag,
    input wire logic service_request,
    input wire logic poll_valid,
    input wire logic [7:0] poll_data,
    output logic poll_strobe,
    output logic [7:0] last_poll,
    output logic [7:0] poll_cnt
);
    logic busy;
    logic [3:0] wait_n;
    // one poll in flight; a slow host idles lag cycles first
    always @(negedge sys_clk) begin
        if (!rst_n) begin
            poll_strobe <= 1'b0;
            busy <= 1'b0;
            wait_n <= 4'h0;
            last_poll <= 8'h00;
            poll_cnt <= 8'h00;
        end else begin
            poll_strobe <= 1'b0;
            if (poll_valid) begin
                busy <= 1'b0;
                last_poll <= poll_data;
                poll_cnt <= poll_cnt + 8'h01;
            end else if (!busy && (force_poll || (auto_en && service_request))) begin
                if (force_poll || wait_n >= lag) begin
                    poll_strobe <= 1'b1;
                    busy <= 1'b1;
                    wait_n <= 4'h0;
                end else begin
                    wait_n <= wait_n + 4'h1;
                end
            end
        end
    end
endmodule

//--- bench/ssr_status_asserts.sv
/*
 * checker: poll and command answer timing, live poll bits, flush.
 * assumes binding into ssr_status_core; one clock domain.
 */
`timescale 1ns/1ps
module ssr_status_asserts (
    input logic sys_clk,
    input logic rst_n,
    input logic ce,
    input logic cmd_valid,
    input ssr_pkg::ssr_cmd_t cmd,
    input logic rsp_valid,
    input logic poll_strobe,
    input logic poll_valid,
    input logic [7:0] poll_data,
    input logic service_request,
    input logic queue_flush,
    input logic input_queue_overflow,
    input logic output_queue_overflow,
    input logic scan_running,
    input logic scan_paused,
    input logic cmd_executing,
    input logic out_buf_nonempty
);
    logic is_rd;
    logic ovf;
    assign is_rd = cmd.op inside {ssr_pkg::OP_RD_STAT, ssr_pkg::OP_RD_STAT_BIT,
        ssr_pkg::OP_RD_EN, ssr_pkg::OP_RD_EN_BIT};
    assign ovf = input_queue_overflow || output_queue_overflow;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////////////
    a_poll_answer_lat: assert property (ce && poll_strobe |=> poll_valid)
        else $error("poll not answered");
    a_poll_scan_bit: assert property (ce && poll_strobe |=>
        poll_data[0] == $past(!(scan_running || scan_paused))) else $error("scan bit wrong");
    a_poll_idle_bits: assert property (ce && poll_strobe |=>
        poll_data[1] == $past(!cmd_executing) && poll_data[4] == $past(out_buf_nonempty))
        else $error("idle or buffer bit wrong");
    a_poll_top_zero: assert property (poll_valid |-> !poll_data[7])
        else $error("unused poll bit set");
    a_poll_req_bit: assert property (poll_valid |-> poll_data[6] == $past(service_request))
        else $error("polled request bit wrong");
    a_req_fall_poll: assert property ($fell(service_request) |-> $past(poll_strobe))
        else $error("request dropped without poll");
    a_read_answer: assert property (ce && cmd_valid && is_rd |=> rsp_valid)
        else $error("read not answered");
    a_write_silent: assert property (ce && cmd_valid && !is_rd |=> !rsp_valid)
        else $error("answer to non-read");
    a_flush_on_ovf: assert property (ce && ovf |=> queue_flush)
        else $error("no flush on overflow");
    a_flush_cause: assert property (queue_flush |-> $past(ovf))
        else $error("flush without overflow");
    ////////////////////////////////////////////////////////////////////////
    cover property (poll_valid && poll_data[6]);
    cover property (rsp_valid);
    cover property (queue_flush);
endmodule

bind ssr_status_core ssr_status_asserts i_chk (
    .sys_clk, .rst_n, .ce, .cmd_valid, .cmd, .rsp_valid, .poll_strobe, .poll_valid,
    .poll_data, .service_request, .queue_flush, .input_queue_overflow,
    .output_queue_overflow, .scan_running, .scan_paused, .cmd_executing, .out_buf_nonempty
);

//--- bench/testbench.sv
/*
 * self-checking bench for ssr_status_core with a polling host model.
 * assumes the core answers reads one cycle after the command edge.
 */
`timescale 1ns/1ps
module testbench;
    logic sys_clk, rst_n, cmd_valid, rsp_valid, poll_strobe, poll_valid;
    logic service_request, scan_running, scan_paused, cmd_executing, out_buf_nonempty;
    logic freq_valid, trigger_seen_mode_armed, auto_en, force_poll;
    logic [7:0] sev, mev, fev, rsp_data, poll_data, last_poll, poll_cnt;
    logic [23:0] det_freq_chz;
    logic [3:0] lag;
    ssr_pkg::ssr_cmd_t cmd;
    int err_total, checked;

    ssr_status_core i_dut (
        .sys_clk, .rst_n, .ce(1'b1), .cmd_valid, .cmd, .rsp_valid, .rsp_data, .poll_strobe,
        .poll_valid, .poll_data, .service_request, .queue_flush(), .scan_running,
        .scan_paused, .cmd_executing, .out_buf_nonempty,
        .input_queue_overflow(sev[0]), .output_queue_overflow(sev[2]),
        .execution_fault(sev[4]), .illegal_command(sev[5]), .user_activity(sev[6]),
        .power_on_event(sev[7]), .input_reserve_overload(mev[0]),
        .filter_overload(mev[1]), .output_overload(mev[2]), .reference_unlock(mev[3]),
        .freq_valid, .det_freq_chz, .time_constant_changed(mev[5]), .trigger_seen(mev[6]),
        .trigger_seen_mode_armed, .plot_done(mev[7]),
        .print_plot_fault(fev[0]), .backup_fault(fev[1]), .ram_test_fault(fev[2]),
        .disk_fault(fev[3]), .rom_test_fault(fev[4]), .fast_xfer_abort(fev[5]),
        .dsp_test_fault(fev[6]), .math_fault(fev[7])
    );
    ssr_gpib_host i_host (
        .sys_clk, .rst_n, .auto_en, .force_poll, .lag, .service_request, .poll_valid,
        .poll_data, .poll_strobe, .last_poll, .poll_cnt
    );
    always #25 sys_clk = ~sys_clk;
    ////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish;
        $display("checks=%0d errors=%0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input ssr_pkg::ssr_op_t o, input ssr_pkg::ssr_tgt_t t,
            input logic [2:0] i, input logic [7:0] d);
        @(negedge sys_clk);
        cmd_valid = 1'b1;
        cmd = {o, t, i, d};
        @(negedge sys_clk);
        cmd_valid = 1'b0;
    endtask
    task automatic rd(input ssr_pkg::ssr_op_t o, input ssr_pkg::ssr_tgt_t t,
            input logic [2:0] i, input logic [7:0] exp);
        wr(o, t, i, 8'h00);
        chk({7'h00, rsp_valid}, 8'h01);
        chk(rsp_data, exp);
    endtask
    task automatic rs(input ssr_pkg::ssr_tgt_t t, input logic [7:0] exp);
        rd(ssr_pkg::OP_RD_STAT, t, 3'h0, exp);
    endtask
    task automatic pulse(input logic [7:0] s, input logic [7:0] m, input logic [7:0] f);
        @(negedge sys_clk);
        sev = s;
        mev = m;
        fev = f;
        @(negedge sys_clk);
        sev = 8'h00;
        mev = 8'h00;
        fev = 8'h00;
    endtask
    task automatic fsamp(input logic [23:0] v);
        @(negedge sys_clk);
        det_freq_chz = v;
        freq_valid = 1'b1;
        @(negedge sys_clk);
        freq_valid = 1'b0;
    endtask
    task automatic poll_wait(input logic [7:0] exp, input logic manual);
        logic [7:0] n0;
        n0 = poll_cnt;
        if (manual) begin
            @(negedge sys_clk);
            force_poll <= 1'b1;
            @(negedge sys_clk);
            force_poll <= 1'b0;
        end
        for (int k = 0; k < 40 && poll_cnt == n0; k++) begin
            @(negedge sys_clk);
        end
        if (poll_cnt == n0) begin
            err_total++;
            tally_and_finish();
        end
        chk(last_poll, exp);
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset_vals;
        for (int k = 0; k < 4; k++) begin
            rd(ssr_pkg::OP_RD_EN, ssr_pkg::ssr_tgt_t'(k), 3'h0, 8'h00);
            rs(ssr_pkg::ssr_tgt_t'(k), k == 0 ? 8'h03 : 8'h00);
        end
    endtask
    task automatic t_events;
        logic [7:0] ex [4];
        ex = '{8'h03, 8'hf5, 8'hef, 8'hff};
        trigger_seen_mode_armed = 1'b1;
        pulse(8'hff, 8'hef, 8'hff);
        for (int k = 1; k < 4; k++) begin
            rs(ssr_pkg::ssr_tgt_t'(k), ex[k]);
            rs(ssr_pkg::ssr_tgt_t'(k), 8'h00);
        end
        pulse(8'h50, 8'h00, 8'h24);
        rd(ssr_pkg::OP_RD_STAT_BIT, ssr_pkg::TG_STD, 3'h6, 8'h01);
        rs(ssr_pkg::TG_STD, 8'h10);
        wr(ssr_pkg::OP_CLEAR, ssr_pkg::TG_POLL, 3'h0, 8'h00);
        rs(ssr_pkg::TG_FAULT, 8'h00);
        trigger_seen_mode_armed = 1'b0;
        pulse(8'h00, 8'h40, 8'h00);
        rs(ssr_pkg::TG_MEAS, 8'h00);
    endtask
    task automatic t_range;
        logic [23:0] fv [5];
        logic [7:0] ex [5];
        // seed high, below, at low edge, above, at high edge
        fv = '{24'h004f59, 24'h004dd0, 24'h004dd1, 24'h004f59, 24'h004f58};
        ex = '{8'h00, 8'h10, 8'h00, 8'h10, 8'h00};
        for (int k = 0; k < 5; k++) begin
            fsamp(fv[k]);
            rs(ssr_pkg::TG_MEAS, ex[k]);
        end
    endtask
    task automatic t_enables;
        wr(ssr_pkg::OP_WR_EN, ssr_pkg::TG_STD, 3'h0, 8'ha5);
        wr(ssr_pkg::OP_WR_EN_BIT, ssr_pkg::TG_STD, 3'h1, 8'h01);
        wr(ssr_pkg::OP_WR_EN_BIT, ssr_pkg::TG_STD, 3'h0, 8'h00);
        wr(ssr_pkg::OP_CLEAR, ssr_pkg::TG_STD, 3'h0, 8'h00);
        rd(ssr_pkg::OP_RD_EN, ssr_pkg::TG_STD, 3'h0, 8'ha6);
        rd(ssr_pkg::OP_RD_EN_BIT, ssr_pkg::TG_STD, 3'h2, 8'h01);
        pulse(8'h80, 8'h00, 8'h00);
        rs(ssr_pkg::TG_POLL, 8'h23);
        rs(ssr_pkg::TG_STD, 8'h80);
        rs(ssr_pkg::TG_POLL, 8'h03);
        wr(ssr_pkg::OP_WR_EN, ssr_pkg::TG_POLL, 3'h0, 8'hc0);
        rd(ssr_pkg::OP_RD_EN, ssr_pkg::TG_POLL, 3'h0, 8'h00);
    endtask
    task automatic t_live_bits;
        scan_running = 1'b1;
        scan_paused = 1'b1;
        rs(ssr_pkg::TG_POLL, 8'h02);
        scan_running = 1'b0;
        scan_paused = 1'b0;
        cmd_executing = 1'b1;
        out_buf_nonempty = 1'b1;
        rs(ssr_pkg::TG_POLL, 8'h11);
        cmd_executing = 1'b0;
        out_buf_nonempty = 1'b0;
    endtask
    task automatic t_service;
        logic [7:0] n1;
        wr(ssr_pkg::OP_WR_EN, ssr_pkg::TG_MEAS, 3'h0, 8'h03);
        wr(ssr_pkg::OP_WR_EN_BIT, ssr_pkg::TG_POLL, 3'h3, 8'h01);
        pulse(8'h00, 8'h03, 8'h00);
        poll_wait(8'h4b, 1'b0);
        n1 = poll_cnt;
        // a held status bit must not re-request
        pulse(8'h00, 8'h01, 8'h00);
        repeat (10) @(negedge sys_clk);
        chk(poll_cnt, n1);
        chk({7'h00, service_request}, 8'h00);
        rs(ssr_pkg::TG_POLL, 8'h4b);
        rs(ssr_pkg::TG_POLL, 8'h4b);
        poll_wait(8'h0b, 1'b1);
        rd(ssr_pkg::OP_RD_STAT_BIT, ssr_pkg::TG_MEAS, 3'h1, 8'h01);
        rs(ssr_pkg::TG_POLL, 8'h4b);
        rs(ssr_pkg::TG_MEAS, 8'h01);
        rs(ssr_pkg::TG_POLL, 8'h03);
        lag <= 4'h5;
        pulse(8'h00, 8'h01, 8'h00);
        poll_wait(8'h4b, 1'b0);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        {sys_clk, rst_n, cmd_valid, freq_valid, trigger_seen_mode_armed, force_poll} = 6'h00;
        {scan_running, scan_paused, cmd_executing, out_buf_nonempty} = 4'h0;
        {sev, mev, fev} = 24'h000000;
        det_freq_chz = 24'h000000;
        cmd = 16'h0000;
        auto_en = 1'b1;
        lag = 4'h0;
        err_total = 0;
        checked = 0;
        repeat (12) @(negedge sys_clk);
        rst_n = 1'b1;
        t_reset_vals();
        t_events();
        t_range();
        t_enables();
        t_live_bits();
        t_service();
        tally_and_finish();
    end
endmodule

//--- rtl/ssr_pkg.sv
/*
 * shared constants, command encodings and the carrier struct for the
 * status and service request block.
 * assumes one clock domain; all users name items as ssr_pkg::name.
 */
// Notes on behaviour
// - four eight-bit status bytes: poll summary, standard event, measurement, fault.
// - a status bit is one while its event happened or condition holds.
// - poll bit 0 high only when no scan runs; paused counts as running.
// - poll bit 1 high when idle; bit 4 high while output buffer holds data.
// - poll bits 2,3,5 are OR of fault, measurement, event bytes AND enables.
// - summary bit stays set until all enabled bits below it are cleared.
// - query read of the poll byte clears nothing; bits track live conditions.
// - query bit 6 shows any enabled poll bit set, regardless of polling.
// - serial poll returns bit 6 once per request and clears only the request.
// - several enabled bits in one byte give one request until summary clears.
// - event bits 0,2,4,5,6,7 set on their causes; overflow flushes both queues.
// - standard event bits stick until read or clear-status.
// - measurement bits 0 to 3 set on overloads and reference unlock.
// - measurement bit 4 sets when frequency crosses between its two ranges.
// - bit 5 on indirect time constant change, 6 on armed trigger, 7 plot.
// - measurement bits stick until read or clear-status.
// - fault bits 2,4,6 set on memory, program store and processor test faults.
// - fault bit 5 on aborted fast transfer; 0,1,3,7 on other faults.
// - fault bits stick until read or clear-status.
// - whole-byte read clears the byte; indexed bit read clears that bit.
// - clear-status clears every status byte, leaves enables alone.
// - enables written and read as a whole byte or one indexed bit.
package ssr_pkg;

    localparam logic [7:0] STATUS_RST = 8'h00;
    localparam logic [7:0] ENABLE_RST = 8'h00;
    localparam logic [7:0] STD_USED = 8'hf5;
    localparam logic [7:0] SP_USED = 8'h3f;
    localparam logic [7:0] ALL_USED = 8'hff;
    localparam int SP_SCAN = 0;
    localparam int SP_IDLE = 1;
    localparam int SP_FAULT = 2;
    localparam int SP_MEAS = 3;
    localparam int SP_OUTBUF = 4;
    localparam int SP_STD = 5;
    localparam int SP_REQ = 6;
    // range thresholds in hundredths of a hertz
    localparam int FREQ_W = 24;
    localparam logic [23:0] RANGE_LO_CHZ = 24'h004dd1;
    localparam logic [23:0] RANGE_HI_CHZ = 24'h004f58;

    typedef enum logic [2:0] {
        OP_NONE = 3'h0,
        OP_RD_STAT = 3'h1,
        OP_RD_STAT_BIT = 3'h3,
        OP_RD_EN = 3'h2,
        OP_RD_EN_BIT = 3'h6,
        OP_WR_EN = 3'h7,
        OP_WR_EN_BIT = 3'h5,
        OP_CLEAR = 3'h4
    } ssr_op_t;

    typedef enum logic [1:0] {
        TG_POLL = 2'h0,
        TG_STD = 2'h1,
        TG_MEAS = 2'h2,
        TG_FAULT = 2'h3
    } ssr_tgt_t;

    typedef struct packed {
        ssr_op_t op;
        ssr_tgt_t target;
        logic [2:0] idx;
        logic [7:0] data;
    } ssr_cmd_t;

    function automatic logic [7:0] bit_mask(input logic [2:0] idx);
        bit_mask = 8'h01 << idx;
    endfunction

endpackage

//--- rtl/ssr_req_gen.sv
/*
 * service request generator: rising enabled poll bits raise a
 * request that a serial poll clears.
 * assumes poll strobe is a one-cycle pulse on sys_clk.
 */
`timescale 1ns/1ps
module ssr_req_gen (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [7:0] live,
    input wire logic poll,
    output logic pending
);

    logic [7:0] prev_r;
    logic rise;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            prev_r <= ssr_pkg::STATUS_RST;
        end else if (ce) begin
            prev_r <= live;
        end
    end

    // a held bit gives no second edge
    assign rise = |(live & ~prev_r);

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            pending <= 1'b0;
        end else if (ce) begin
            pending <= rise | (pending & ~poll);
        end
    end

endmodule

//--- rtl/ssr_status_core.sv
/*
 * status reporting core: four status bytes, their enables, the
 * poll summary, query and serial poll answers and service request.
 * assumes commands, poll strobes and event pulses come from logic
 * on sys_clk; condition levels are likewise synchronous.
 */
`timescale 1ns/1ps
module ssr_status_core (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic ce,
    // command port from the parser
    input wire logic cmd_valid,
    input wire ssr_pkg::ssr_cmd_t cmd,
    output logic rsp_valid,
    output logic [7:0] rsp_data,
    // serial poll from the bus interface
    input wire logic poll_strobe,
    output logic poll_valid,
    output logic [7:0] poll_data,
    output logic service_request,
    output logic queue_flush,
    // live conditions
    input wire logic scan_running,
    input wire logic scan_paused,
    input wire logic cmd_executing,
    input wire logic out_buf_nonempty,
    // standard event causes
    input wire logic input_queue_overflow,
    input wire logic output_queue_overflow,
    input wire logic execution_fault,
    input wire logic illegal_command,
    input wire logic user_activity,
    input wire logic power_on_event,
    // measurement causes
    input wire logic input_reserve_overload,
    input wire logic filter_overload,
    input wire logic output_overload,
    input wire logic reference_unlock,
    input wire logic freq_valid,
    input wire logic [23:0] det_freq_chz,
    input wire logic time_constant_changed,
    input wire logic trigger_seen,
    input wire logic trigger_seen_mode_armed,
    input wire logic plot_done,
    // fault causes
    input wire logic print_plot_fault,
    input wire logic backup_fault,
    input wire logic ram_test_fault,
    input wire logic disk_fault,
    input wire logic rom_test_fault,
    input wire logic fast_xfer_abort,
    input wire logic dsp_test_fault,
    input wire logic math_fault
);

    ////////////////////////////////////////////////////////////////
    // command decode

    logic is_rd_stat;
    logic is_rd_bit;
    logic is_wr_en;
    logic is_wr_en_bit;
    logic is_clear;
    logic [7:0] idx_mask;
    logic [7:0] rd_clr_vec;
    logic [7:0] en_wmask;
    logic [7:0] en_wdata;
    logic [3:0] tgt_hit;

    assign is_rd_stat = cmd_valid && (cmd.op == ssr_pkg::OP_RD_STAT);
    assign is_rd_bit = cmd_valid && (cmd.op == ssr_pkg::OP_RD_STAT_BIT);
    assign is_wr_en = cmd_valid && (cmd.op == ssr_pkg::OP_WR_EN);
    assign is_wr_en_bit = cmd_valid && (cmd.op == ssr_pkg::OP_WR_EN_BIT);
    assign is_clear = cmd_valid && (cmd.op == ssr_pkg::OP_CLEAR);
    assign idx_mask = ssr_pkg::bit_mask(cmd.idx);

    always_comb begin
        tgt_hit = 4'h0;
        tgt_hit[cmd.target] = 1'b1;
    end

    // whole read clears the byte, indexed read only its bit
    always_comb begin
        rd_clr_vec = 8'h00;
        if (is_rd_stat) begin
            rd_clr_vec = 8'hff;
        end else if (is_rd_bit) begin
            rd_clr_vec = idx_mask;
        end
        if (is_clear) begin
            rd_clr_vec = 8'hff;
        end
    end

    // bit write takes data bit 0 as the new value
    always_comb begin
        en_wmask = 8'h00;
        en_wdata = cmd.data;
        if (is_wr_en) begin
            en_wmask = 8'hff;
        end else if (is_wr_en_bit) begin
            en_wmask = idx_mask;
            en_wdata = {8{cmd.data[0]}};
        end
    end

    ////////////////////////////////////////////////////////////////
    // detection frequency range tracking

    logic range_hi_r;
    logic range_primed_r;
    logic range_nxt;
    logic range_event;

    // between the thresholds the current range is kept (hysteresis)
    always_comb begin
        range_nxt = range_hi_r;
        if (det_freq_chz < ssr_pkg::RANGE_LO_CHZ) begin
            range_nxt = 1'b0;
        end else if (det_freq_chz > ssr_pkg::RANGE_HI_CHZ) begin
            range_nxt = 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            range_hi_r <= 1'b0;
        end else if (ce && freq_valid) begin
            range_hi_r <= range_nxt;
        end
    end

    // first sample after reset only seeds the range, no event
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            range_primed_r <= 1'b0;
        end else if (ce && freq_valid) begin
            range_primed_r <= 1'b1;
        end
    end

    assign range_event = freq_valid && range_primed_r
        && (range_nxt != range_hi_r);

    ////////////////////////////////////////////////////////////////
    // event vectors

    logic [7:0] std_set;
    logic [7:0] meas_set;
    logic [7:0] fault_set;

    assign std_set = {
        power_on_event,
        user_activity,
        illegal_command,
        execution_fault,
        1'b0,
        output_queue_overflow,
        1'b0,
        input_queue_overflow
    };

    assign meas_set = {
        plot_done,
        trigger_seen & trigger_seen_mode_armed,
        time_constant_changed,
        range_event,
        reference_unlock,
        output_overload,
        filter_overload,
        input_reserve_overload
    };

    assign fault_set = {
        math_fault,
        dsp_test_fault,
        fast_xfer_abort,
        rom_test_fault,
        disk_fault,
        ram_test_fault,
        backup_fault,
        print_plot_fault
    };

    ////////////////////////////////////////////////////////////////
    // sticky status bytes

    logic [7:0] std_stat;
    logic [7:0] std_en;
    logic std_sum;
    logic [7:0] meas_stat;
    logic [7:0] meas_en;
    logic meas_sum;
    logic [7:0] fault_stat;
    logic [7:0] fault_en;
    logic fault_sum;

    ssr_sticky_byte #(
        .USED(ssr_pkg::STD_USED)
    ) u_std (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .ce(ce),
        .set_vec(std_set),
        .clr_vec(tgt_hit[ssr_pkg::TG_STD] || is_clear ? rd_clr_vec : 8'h00),
        .en_wr(tgt_hit[ssr_pkg::TG_STD]),
        .en_wmask(en_wmask),
        .en_data(en_wdata),
        .status(std_stat),
        .enable(std_en),
        .summary(std_sum)
    );

    ssr_sticky_byte #(
        .USED(ssr_pkg::ALL_USED)
    ) u_meas (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .ce(ce),
        .set_vec(meas_set),
        .clr_vec(tgt_hit[ssr_pkg::TG_MEAS] || is_clear ? rd_clr_vec : 8'h00),
        .en_wr(tgt_hit[ssr_pkg::TG_MEAS]),
        .en_wmask(en_wmask),
        .en_data(en_wdata),
        .status(meas_stat),
        .enable(meas_en),
        .summary(meas_sum)
    );

    ssr_sticky_byte #(
        .USED(ssr_pkg::ALL_USED)
    ) u_fault (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .ce(ce),
        .set_vec(fault_set),
        .clr_vec(tgt_hit[ssr_pkg::TG_FAULT] || is_clear ? rd_clr_vec : 8'h00),
        .en_wr(tgt_hit[ssr_pkg::TG_FAULT]),
        .en_wmask(en_wmask),
        .en_data(en_wdata),
        .status(fault_stat),
        .enable(fault_en),
        .summary(fault_sum)
    );

    ////////////////////////////////////////////////////////////////
    // serial poll byte and its enable

    logic [7:0] sp_en_r;
    logic [7:0] sp_live;
    logic [7:0] sp_query;
    logic req_pending;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            sp_en_r <= ssr_pkg::ENABLE_RST;
        end else if (ce && tgt_hit[ssr_pkg::TG_POLL]) begin
            // bit 6 and 7 enables do not exist
            sp_en_r <= ((sp_en_r & ~en_wmask) | (en_wdata & en_wmask))
                & ssr_pkg::SP_USED;
        end
    end

    always_comb begin
        sp_live = 8'h00;
        sp_live[ssr_pkg::SP_SCAN] = !(scan_running || scan_paused);
        sp_live[ssr_pkg::SP_IDLE] = !cmd_executing;
        sp_live[ssr_pkg::SP_FAULT] = fault_sum;
        sp_live[ssr_pkg::SP_MEAS] = meas_sum;
        sp_live[ssr_pkg::SP_OUTBUF] = out_buf_nonempty;
        sp_live[ssr_pkg::SP_STD] = std_sum;
    end

    // query view: bit 6 is the live enabled-and-set state
    always_comb begin
        sp_query = sp_live;
        sp_query[ssr_pkg::SP_REQ] = |(sp_live & sp_en_r);
    end

    ssr_req_gen u_req (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .ce(ce),
        .live(sp_live & sp_en_r),
        .poll(poll_strobe),
        .pending(req_pending)
    );

    assign service_request = req_pending;

    ////////////////////////////////////////////////////////////////
    // serial poll answer

    // captured before the clear lands, so the first poll sees the request
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            poll_data <= 8'h00;
        end else if (ce && poll_strobe) begin
            poll_data <= {1'b0, req_pending, sp_live[5:0]};
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            poll_valid <= 1'b0;
        end else if (ce) begin
            poll_valid <= poll_strobe;
        end
    end

    ////////////////////////////////////////////////////////////////
    // query answers

    logic [7:0] stat_sel;
    logic [7:0] en_sel;
    logic [7:0] rsp_nxt;
    logic rsp_is_read;

    always_comb begin
        case (cmd.target)
            ssr_pkg::TG_POLL: begin
                stat_sel = sp_query;
                en_sel = sp_en_r;
            end
            ssr_pkg::TG_STD: begin
                stat_sel = std_stat;
                en_sel = std_en;
            end
            ssr_pkg::TG_MEAS: begin
                stat_sel = meas_stat;
                en_sel = meas_en;
            end
            default: begin
                stat_sel = fault_stat;
                en_sel = fault_en;
            end
        endcase
    end

    always_comb begin
        rsp_is_read = 1'b1;
        case (cmd.op)
            ssr_pkg::OP_RD_STAT: rsp_nxt = stat_sel;
            ssr_pkg::OP_RD_STAT_BIT: rsp_nxt = {7'h00, stat_sel[cmd.idx]};
            ssr_pkg::OP_RD_EN: rsp_nxt = en_sel;
            ssr_pkg::OP_RD_EN_BIT: rsp_nxt = {7'h00, en_sel[cmd.idx]};
            default: begin
                rsp_nxt = 8'h00;
                rsp_is_read = 1'b0;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            rsp_data <= 8'h00;
        end else if (ce && cmd_valid && rsp_is_read) begin
            rsp_data <= rsp_nxt;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            rsp_valid <= 1'b0;
        end else if (ce) begin
            rsp_valid <= cmd_valid && rsp_is_read;
        end
    end

    ////////////////////////////////////////////////////////////////
    // queue flush on either overflow

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            queue_flush <= 1'b0;
        end else if (ce) begin
            queue_flush <= input_queue_overflow || output_queue_overflow;
        end
    end

endmodule

//--- rtl/ssr_sticky_byte.sv
/*
 * one sticky status byte with its enable register and summary.
 * assumes set pulses and clear strobes on sys_clk.
 */
`timescale 1ns/1ps
module ssr_sticky_byte #(
    parameter logic [7:0] USED = 8'hff
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [7:0] set_vec,
    input wire logic [7:0] clr_vec,
    input wire logic en_wr,
    input wire logic [7:0] en_wmask,
    input wire logic [7:0] en_data,
    output logic [7:0] status,
    output logic [7:0] enable,
    output logic summary
);

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            status <= ssr_pkg::STATUS_RST;
        end else if (ce) begin
            // set wins over a clear in the same cycle
            status <= ((status & ~clr_vec) | set_vec) & USED;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            enable <= ssr_pkg::ENABLE_RST;
        end else if (ce && en_wr) begin
            enable <= (enable & ~en_wmask) | (en_data & en_wmask);
        end
    end

    assign summary = |(status & enable);

endmodule
